/* File: scb_pkg.sv */
// scb_pkg: offsets, field positions, reset values and queue depth for the
// byte-mode register bank. assumes nothing beyond a sv-2012 compiler.
package scb_pkg;
	localparam logic [4:0] OFS_RX_STATUS = 5'h00;
	localparam logic [4:0] OFS_RX_CONTROL = 5'h01;
	localparam logic [4:0] OFS_RX_DATA = 5'h02;
	localparam logic [4:0] OFS_RSVD_A = 5'h03;
	localparam logic [4:0] OFS_RX_VECTOR = 5'h04;
	localparam logic [4:0] OFS_RX_IRQ_EN = 5'h05;
	localparam logic [4:0] OFS_TX_STATUS = 5'h08;
	localparam logic [4:0] OFS_TX_CONTROL = 5'h09;
	localparam logic [4:0] OFS_TX_DATA = 5'h0a;
	localparam logic [4:0] OFS_RSVD_B = 5'h0b;
	localparam logic [4:0] OFS_TX_VECTOR = 5'h0c;
	localparam logic [4:0] OFS_TX_IRQ_EN = 5'h0d;
	localparam logic [4:0] OFS_ML_STATUS = 5'h10;
	localparam logic [4:0] OFS_ML_CONTROL = 5'h11;
	localparam logic [4:0] OFS_RSVD_C = 5'h12;
	localparam logic [4:0] OFS_RSVD_D = 5'h13;
	localparam logic [4:0] OFS_ML_VECTOR = 5'h14;
	localparam logic [4:0] OFS_ML_IRQ_EN = 5'h15;
	localparam logic [4:0] OFS_PROTO_LOW = 5'h18;
	localparam logic [4:0] OFS_PROTO_HIGH = 5'h19;
	localparam logic [4:0] OFS_ADDR_PAD = 5'h1a;
	localparam logic [4:0] OFS_ADDR_SYNC = 5'h1b;
	localparam logic [4:0] OFS_DIV_LOW = 5'h1c;
	localparam logic [4:0] OFS_DIV_HIGH = 5'h1d;
	localparam logic [4:0] OFS_CLOCKING = 5'h1e;
	localparam logic [4:0] OFS_CHECK = 5'h1f;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_RX_CONTROL = 8'h01;
	localparam logic [7:0] RST_TX_STATUS = 8'h80;
	localparam logic [7:0] RST_TX_CONTROL = 8'h01;
	localparam logic [7:0] RST_VECTOR = 8'h0f;
	localparam logic [7:0] RST_DIV_LOW = 8'h01;
	localparam logic [7:0] RST_CHECK = 8'h04;
	localparam logic [7:0] NULL_READ = 8'hff;
	localparam logic [7:0] RSVD_READ = 8'h00;

	// writable / readable bit masks; zero bits read zero
	localparam logic [7:0] MASK_RX_STATUS = 8'hdf;
	localparam logic [7:0] MASK_RX_CONTROL = 8'h7b;
	localparam logic [7:0] MASK_RX_IRQ_EN = 8'hde;
	localparam logic [7:0] MASK_TX_STATUS = 8'hc6;
	localparam logic [7:0] MASK_TX_IRQ_EN = 8'hc6;
	localparam logic [7:0] MASK_ML_FLAGS = 8'he0;
	localparam logic [7:0] MASK_ML_CONTROL = 8'hc6;
	localparam logic [7:0] MASK_ML_IRQ_EN = 8'he0;
	localparam logic [7:0] MASK_PROTO_LOW = 8'h03;
	localparam logic [7:0] MASK_PROTO_HIGH = 8'h7f;
	localparam logic [7:0] MASK_CLOCKING = 8'h1f;
	localparam logic [7:0] MASK_CHECK = 8'hcf;

	localparam int RX_DATA_AVAIL_BIT = 7;
	localparam int RX_SOFT_RESET_BIT = 0;
	localparam int TX_SPACE_BIT = 7;
	localparam int CTS_T_BIT = 7;
	localparam int DSR_T_BIT = 6;
	localparam int DCD_T_BIT = 5;
	localparam int CTS_L_BIT = 4;
	localparam int DSR_L_BIT = 3;
	localparam int DCD_L_BIT = 2;
	localparam int SEND_REQ_BIT = 7;
	localparam int TERM_READY_BIT = 6;
	localparam int ECHO_BIT = 2;
	localparam int TEST_BIT = 1;

	localparam int QUEUE_DEPTH = 8;
	localparam int DATA_W = 8;
endpackage

/* File: scb_queue.sv */
// scb_queue: byte queue with pointers only under reset; stored data is
// never initialized. a push while full is dropped here (do_push checks full).
`timescale 1ns/1ps
module scb_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head_data,
	output logic empty,
	output logic full
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic do_push;
	logic do_pop;

	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign empty = (count == '0);
	assign full = (count == DEPTH[PW:0]);
	assign head_data = mem[rd_ptr];

	// no reset on storage: contents survive reset on purpose
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
		end
	end
endmodule

/* File: scb_sync.sv */
// scb_sync: two-flop synchroniser per bit for asynchronous pins.
// assumes each bit is an independent level.
`timescale 1ns/1ps
module scb_sync #(
	parameter int WIDTH = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage1[i] <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

/* File: scb_regmap.sv */
// scb_regmap: byte-mode register bank of a serial controller with the
// receive and transmit queues behind their data ports.
// assumes a synchronous one-cycle host strobe (cs, rd/wr) on ref_clk and
// receiver/transmitter engines on the same clock; modem pins are async.
//
// Notes on behaviour
// - each register decoded alone on five address lines; status even, control odd
// - read of offset 02 pops next byte from eight-entry receive queue
// - reset returns receive queue pointer to start, data untouched
// - write of offset 0A pushes a byte into eight-entry transmit queue
// - reset returns transmit queue pointer to start, data left uninitialized
// - reset values: tx status 80; rx/tx control, divisor low 01; check 04
// - vector registers reset to 0F; all others reset to 00
// - data ports are eight bits wide in byte mode
// - rx status bits: avail, eof, 0, check err, framing, overrun, abort, idle
// - tx status: space bit7, complete bit6, underrun bit2, fault bit1, rest zero
// - modem status: transition flags bits 7-5, current levels bits 4-2
// - modem control: send request bit7, terminal ready bit6, echo bit2, test bit1
// - rx irq enable bits align with rx status flags
// - tx irq enable bits align with tx status bits
// - modem irq enable in bits 7-5, lower bits read zero
// - protocol low: control extend bit1, address extend bit0, upper zero
// - protocol high: stop bits 6:5, char length 4:3, protocol 2:0
// - divisor is high byte at 1D over low byte at 1C
// - check control: parity enable bit7, odd bit6, crc select 3:0
// - clocking control: prescale, tx clock out, rx clock in, divide 1:0
// - address registers hold station address, pad or sync character
// - unassigned offsets read all ones; unused bits read zero
// - rx status flags except avail clear on write one; all clear on soft reset or hardware reset
`timescale 1ns/1ps
module scb_regmap #(
	parameter int DEPTH = scb_pkg::QUEUE_DEPTH,
	parameter int WIDTH = scb_pkg::DATA_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs,
	input wire logic rd,
	input wire logic wr,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic rx_push,
	input wire logic [WIDTH-1:0] rx_push_data,
	input wire logic [7:0] rx_events,
	input wire logic tx_pop,
	input wire logic [7:0] tx_events,
	output logic [WIDTH-1:0] tx_head_data,
	output logic tx_queue_empty,
	input wire logic clear_send_n,
	input wire logic set_ready_n,
	input wire logic carrier_n,
	output logic send_request_n,
	output logic terminal_ready_n,
	output logic [7:0] receiver_control,
	output logic [7:0] transmitter_control,
	output logic [7:0] receiver_irq_enable,
	output logic [7:0] transmitter_irq_enable,
	output logic [7:0] modem_irq_enable,
	output logic [7:0] receiver_vector_number,
	output logic [7:0] transmitter_vector_number,
	output logic [7:0] modem_vector_number,
	output logic [7:0] modem_line_control,
	output logic [7:0] protocol_select_low,
	output logic [7:0] protocol_select_high,
	output logic [7:0] station_address_pad,
	output logic [7:0] station_address_sync,
	output logic [15:0] divisor,
	output logic [7:0] clocking_control,
	output logic [7:0] check_control
);
	logic rd_hit;
	logic wr_hit;
	logic [7:0] sticky_rx;
	logic [7:0] transmitter_status_flags;
	logic [2:0] modem_transitions;
	logic [2:0] modem_levels;
	logic [2:0] modem_levels_q;
	logic [2:0] modem_sync;
	logic rx_empty;
	logic rx_full;
	logic tx_full;
	logic [WIDTH-1:0] rx_head;
	logic rx_pop;
	logic tx_push;
	logic rx_flush;
	logic overrun_event;
	logic [7:0] next_rdata;
	logic [7:0] divisor_low;
	logic [7:0] divisor_high;
	logic [7:0] receiver_status;
	logic [7:0] transmitter_status;
	logic [7:0] modem_line_status;
	logic [7:0] rx_clear;
	logic [7:0] tx_clear;
	logic [2:0] ml_clear;
	logic [2:0] ml_edges;

	assign rd_hit = cs && rd;
	assign wr_hit = cs && wr;
	assign rx_pop = rd_hit && (addr == scb_pkg::OFS_RX_DATA);
	assign tx_push = wr_hit && (addr == scb_pkg::OFS_TX_DATA);
	assign rx_flush = receiver_control[scb_pkg::RX_SOFT_RESET_BIT];
	assign overrun_event = rx_push && rx_full;

	scb_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_receive_queue (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(rx_flush),
		.push(rx_push),
		.push_data(rx_push_data),
		.pop(rx_pop),
		.head_data(rx_head),
		.empty(rx_empty),
		.full(rx_full)
	);

	scb_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_transmit_queue (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(1'b0),
		.push(tx_push),
		.push_data(wdata[WIDTH-1:0]),
		.pop(tx_pop),
		.head_data(tx_head_data),
		.empty(tx_queue_empty),
		.full(tx_full)
	);

	// modem pins active low; levels reported as asserted = 1
	scb_sync #(.WIDTH(3)) u_modem_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in({~clear_send_n, ~set_ready_n, ~carrier_n}),
		.sync_out(modem_sync)
	);
	assign modem_levels = modem_sync;

	// write-one-to-clear masks; a same-cycle event wins over the clear
	always_comb begin
		rx_clear = 8'h00;
		tx_clear = 8'h00;
		ml_clear = 3'b000;
		if (wr_hit && addr == scb_pkg::OFS_RX_STATUS) begin
			rx_clear = wdata & scb_pkg::MASK_RX_STATUS;
		end
		if (wr_hit && addr == scb_pkg::OFS_TX_STATUS) begin
			tx_clear = wdata & scb_pkg::MASK_TX_STATUS;
		end
		if (wr_hit && addr == scb_pkg::OFS_ML_STATUS) begin
			ml_clear = wdata[scb_pkg::CTS_T_BIT:scb_pkg::DCD_T_BIT];
		end
	end

	// data-available is derived from the queue, not sticky
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sticky_rx <= scb_pkg::RST_ZERO;
		end else if (rx_flush) begin
			sticky_rx <= scb_pkg::RST_ZERO;
		end else begin
			sticky_rx <= ((sticky_rx & ~rx_clear)
				| rx_events
				| {5'b00000, overrun_event, 2'b00})
				& scb_pkg::MASK_RX_STATUS
				& ~(8'h01 << scb_pkg::RX_DATA_AVAIL_BIT);
		end
	end

	always_comb begin
		receiver_status = sticky_rx;
		receiver_status[scb_pkg::RX_DATA_AVAIL_BIT] = !rx_empty;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmitter_status_flags <= scb_pkg::RST_ZERO;
		end else begin
			transmitter_status_flags <= ((transmitter_status_flags & ~tx_clear) | tx_events)
				& scb_pkg::MASK_TX_STATUS
				& ~(8'h01 << scb_pkg::TX_SPACE_BIT);
		end
	end

	// space bit mirrors the queue, so reset reads 80 with an empty queue
	always_comb begin
		transmitter_status = transmitter_status_flags;
		transmitter_status[scb_pkg::TX_SPACE_BIT] = !tx_full;
	end

	assign ml_edges = modem_levels ^ modem_levels_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			modem_levels_q <= 3'b000;
			modem_transitions <= 3'b000;
		end else begin
			modem_levels_q <= modem_levels;
			modem_transitions <= (modem_transitions & ~ml_clear) | ml_edges;
		end
	end

	always_comb begin
		modem_line_status = {modem_transitions, modem_levels, 2'b00};
	end

	// control and configuration registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			receiver_control <= scb_pkg::RST_RX_CONTROL;
			transmitter_control <= scb_pkg::RST_TX_CONTROL;
			receiver_vector_number <= scb_pkg::RST_VECTOR;
			transmitter_vector_number <= scb_pkg::RST_VECTOR;
			modem_vector_number <= scb_pkg::RST_VECTOR;
			receiver_irq_enable <= scb_pkg::RST_ZERO;
			transmitter_irq_enable <= scb_pkg::RST_ZERO;
			modem_irq_enable <= scb_pkg::RST_ZERO;
			modem_line_control <= scb_pkg::RST_ZERO;
			protocol_select_low <= scb_pkg::RST_ZERO;
			protocol_select_high <= scb_pkg::RST_ZERO;
			station_address_pad <= scb_pkg::RST_ZERO;
			station_address_sync <= scb_pkg::RST_ZERO;
			divisor_low <= scb_pkg::RST_DIV_LOW;
			divisor_high <= scb_pkg::RST_ZERO;
			clocking_control <= scb_pkg::RST_ZERO;
			check_control <= scb_pkg::RST_CHECK;
		end else if (wr_hit) begin
			// each offset decoded individually
			if (addr == scb_pkg::OFS_RX_CONTROL) begin
				receiver_control <= wdata & scb_pkg::MASK_RX_CONTROL;
			end else if (addr == scb_pkg::OFS_TX_CONTROL) begin
				transmitter_control <= wdata;
			end else if (addr == scb_pkg::OFS_RX_VECTOR) begin
				receiver_vector_number <= wdata;
			end else if (addr == scb_pkg::OFS_RX_IRQ_EN) begin
				receiver_irq_enable <= wdata & scb_pkg::MASK_RX_IRQ_EN;
			end else if (addr == scb_pkg::OFS_TX_VECTOR) begin
				transmitter_vector_number <= wdata;
			end else if (addr == scb_pkg::OFS_TX_IRQ_EN) begin
				transmitter_irq_enable <= wdata & scb_pkg::MASK_TX_IRQ_EN;
			end else if (addr == scb_pkg::OFS_ML_CONTROL) begin
				modem_line_control <= wdata & scb_pkg::MASK_ML_CONTROL;
			end else if (addr == scb_pkg::OFS_ML_VECTOR) begin
				modem_vector_number <= wdata;
			end else if (addr == scb_pkg::OFS_ML_IRQ_EN) begin
				modem_irq_enable <= wdata & scb_pkg::MASK_ML_IRQ_EN;
			end else if (addr == scb_pkg::OFS_PROTO_LOW) begin
				protocol_select_low <= wdata & scb_pkg::MASK_PROTO_LOW;
			end else if (addr == scb_pkg::OFS_PROTO_HIGH) begin
				protocol_select_high <= wdata & scb_pkg::MASK_PROTO_HIGH;
			end else if (addr == scb_pkg::OFS_ADDR_PAD) begin
				station_address_pad <= wdata;
			end else if (addr == scb_pkg::OFS_ADDR_SYNC) begin
				station_address_sync <= wdata;
			end else if (addr == scb_pkg::OFS_DIV_LOW) begin
				divisor_low <= wdata;
			end else if (addr == scb_pkg::OFS_DIV_HIGH) begin
				divisor_high <= wdata;
			end else if (addr == scb_pkg::OFS_CLOCKING) begin
				clocking_control <= wdata & scb_pkg::MASK_CLOCKING;
			end else if (addr == scb_pkg::OFS_CHECK) begin
				check_control <= wdata & scb_pkg::MASK_CHECK;
			end
		end
	end

	// registered copies so divisor, send_request_n and terminal_ready_n leave a flip-flop
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divisor <= {scb_pkg::RST_ZERO, scb_pkg::RST_DIV_LOW};
			send_request_n <= 1'b1;
			terminal_ready_n <= 1'b1;
		end else begin
			divisor <= {divisor_high, divisor_low};
			send_request_n <= ~modem_line_control[scb_pkg::SEND_REQ_BIT];
			terminal_ready_n <= ~modem_line_control[scb_pkg::TERM_READY_BIT];
		end
	end

	// read mux; reserved read zero, unassigned read all ones
	always_comb begin
		next_rdata = scb_pkg::NULL_READ;
		if (addr == scb_pkg::OFS_RX_STATUS) begin
			next_rdata = receiver_status;
		end else if (addr == scb_pkg::OFS_RX_CONTROL) begin
			next_rdata = receiver_control;
		end else if (addr == scb_pkg::OFS_RX_DATA) begin
			next_rdata = rx_empty ? scb_pkg::RST_ZERO : 8'(rx_head);
		end else if (addr == scb_pkg::OFS_RX_VECTOR) begin
			next_rdata = receiver_vector_number;
		end else if (addr == scb_pkg::OFS_RX_IRQ_EN) begin
			next_rdata = receiver_irq_enable;
		end else if (addr == scb_pkg::OFS_TX_STATUS) begin
			next_rdata = transmitter_status;
		end else if (addr == scb_pkg::OFS_TX_CONTROL) begin
			next_rdata = transmitter_control;
		end else if (addr == scb_pkg::OFS_TX_VECTOR) begin
			next_rdata = transmitter_vector_number;
		end else if (addr == scb_pkg::OFS_TX_IRQ_EN) begin
			next_rdata = transmitter_irq_enable;
		end else if (addr == scb_pkg::OFS_ML_STATUS) begin
			next_rdata = modem_line_status;
		end else if (addr == scb_pkg::OFS_ML_CONTROL) begin
			next_rdata = modem_line_control;
		end else if (addr == scb_pkg::OFS_ML_VECTOR) begin
			next_rdata = modem_vector_number;
		end else if (addr == scb_pkg::OFS_ML_IRQ_EN) begin
			next_rdata = modem_irq_enable;
		end else if (addr == scb_pkg::OFS_PROTO_LOW) begin
			next_rdata = protocol_select_low;
		end else if (addr == scb_pkg::OFS_PROTO_HIGH) begin
			next_rdata = protocol_select_high;
		end else if (addr == scb_pkg::OFS_ADDR_PAD) begin
			next_rdata = station_address_pad;
		end else if (addr == scb_pkg::OFS_ADDR_SYNC) begin
			next_rdata = station_address_sync;
		end else if (addr == scb_pkg::OFS_DIV_LOW) begin
			next_rdata = divisor_low;
		end else if (addr == scb_pkg::OFS_DIV_HIGH) begin
			next_rdata = divisor_high;
		end else if (addr == scb_pkg::OFS_CLOCKING) begin
			next_rdata = clocking_control;
		end else if (addr == scb_pkg::OFS_CHECK) begin
			next_rdata = check_control;
		end else if (addr == scb_pkg::OFS_RSVD_A || addr == scb_pkg::OFS_RSVD_B
			|| addr == scb_pkg::OFS_RSVD_C || addr == scb_pkg::OFS_RSVD_D) begin
			// software may not rely on these, zero is the simplest answer
			next_rdata = scb_pkg::RSVD_READ;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= scb_pkg::RST_ZERO;
			rvalid <= 1'b0;
		end else begin
			rvalid <= rd_hit;
			if (rd_hit) begin
				rdata <= next_rdata;
			end
		end
	end
endmodule

/* File: scb_regmap_monitor.sv */
// scb_regmap_monitor: port-level assertions on the byte-mode register bank.
// assumes it is bound onto scb_regmap; one clock, async active-low reset.
`timescale 1ns/1ps
module scb_regmap_monitor #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs,
	input wire logic rd,
	input wire logic wr,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic tx_pop,
	input wire logic tx_queue_empty,
	input wire logic send_request_n,
	input wire logic [7:0] receiver_control,
	input wire logic [7:0] receiver_irq_enable,
	input wire logic [7:0] transmitter_control,
	input wire logic [7:0] receiver_vector_number,
	input wire logic [7:0] transmitter_vector_number,
	input wire logic [7:0] modem_vector_number,
	input wire logic [7:0] modem_line_control,
	input wire logic [15:0] divisor,
	input wire logic [7:0] check_control
);
	default clocking mon_cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] div_shadow;
	// last bytes written to the divisor pair; the port copy may lag a cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_shadow <= 16'h0001;
		end else if (cs && wr && addr == 5'h1c) begin
			div_shadow[7:0] <= wdata;
		end else if (cs && wr && addr == 5'h1d) begin
			div_shadow[15:8] <= wdata;
		end
	end
	property p_read_answer;
		cs && rd |=> rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_no_stray;
		!(cs && rd) |=> !rvalid;
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("rvalid without read");
	property p_null_read;
		cs && rd && (addr inside {5'h06, 5'h07, 5'h0e, 5'h0f, 5'h16, 5'h17}) |=> rdata == 8'hff;
	endproperty
	a_null_read: assert property (p_null_read) else $error("unassigned read not ff");
	property p_reset_ctl;
		$rose(rst_n) |-> receiver_control == 8'h01 && transmitter_control == 8'h01
			&& check_control == 8'h04 && divisor == 16'h0001;
	endproperty
	a_reset_ctl: assert property (p_reset_ctl) else $error("control reset value");
	property p_reset_vec;
		$rose(rst_n) |-> receiver_vector_number == 8'h0f && transmitter_vector_number == 8'h0f
			&& modem_vector_number == 8'h0f && modem_line_control == 8'h00 && send_request_n;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("vector reset value");
	property p_send_req;
		$stable(modem_line_control) [*3] |-> send_request_n == !modem_line_control[7];
	endproperty
	a_send_req: assert property (p_send_req) else $error("send request pin mismatch");
	property p_div;
		$stable(div_shadow) [*3] |-> divisor == div_shadow;
	endproperty
	a_div: assert property (p_div) else $error("divisor byte order");
	property p_tx_push;
		cs && wr && addr == 5'h0a && tx_queue_empty && !tx_pop |=> !tx_queue_empty;
	endproperty
	a_tx_push: assert property (p_tx_push) else $error("transmit write lost");
	property p_check_unused;
		cs && rd && addr == 5'h1f |=> rdata[5:4] == 2'h0;
	endproperty
	a_check_unused: assert property (p_check_unused) else $error("check control unused bits");
	property p_modem_ie_unused;
		cs && rd && addr == 5'h15 |=> rdata[4:0] == 5'h00;
	endproperty
	a_modem_ie_unused: assert property (p_modem_ie_unused) else $error("modem enable low bits");
	property p_rx_ie_port;
		cs && wr && addr == 5'h05 |=> receiver_irq_enable == ($past(wdata) & 8'hde);
	endproperty
	a_rx_ie_port: assert property (p_rx_ie_port) else $error("rx enable port mismatch");
endmodule
bind scb_regmap scb_regmap_monitor #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_mon (.ref_clk(ref_clk),
	.rst_n(rst_n), .cs(cs), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata),
	.rvalid(rvalid), .tx_pop(tx_pop), .tx_queue_empty(tx_queue_empty),
	.send_request_n(send_request_n), .receiver_control(receiver_control),
	.receiver_irq_enable(receiver_irq_enable),
	.transmitter_control(transmitter_control), .receiver_vector_number(receiver_vector_number),
	.transmitter_vector_number(transmitter_vector_number),
	.modem_vector_number(modem_vector_number), .modem_line_control(modem_line_control),
	.divisor(divisor), .check_control(check_control));

/* File: scb_host_model.sv */
// scb_host_model: host processor side, one-cycle strobes on ref_clk.
// assumes the bank answers a read within four cycles.
`timescale 1ns/1ps
module scb_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output logic cs,
	output logic rd,
	output logic wr,
	output logic [4:0] addr,
	output logic [7:0] wdata
);
	initial begin
		cs = 1'h0;
		rd = 1'h0;
		wr = 1'h0;
		addr = 5'h00;
		wdata = 8'h00;
	end
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cs <= 1'h1;
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		cs <= 1'h0;
		wr <= 1'h0;
	endtask
	// strobe held one cycle only: a held read would pop the receive queue twice
	task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic ok);
		ok = 1'h0;
		d = 8'h00;
		@(posedge ref_clk);
		cs <= 1'h1;
		rd <= 1'h1;
		addr <= a;
		@(posedge ref_clk);
		cs <= 1'h0;
		rd <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			if (rvalid === 1'h1) begin
				d = rdata;
				ok = 1'h1;
				break;
			end
		end
	endtask
	// callers never compare data read from reserved offsets
endmodule

/* File: tb_serial_controller_byte_regmap.sv */
// tb_serial_controller_byte_regmap: directed register and queue tests.
// assumes scb_pkg, scb_queue, scb_sync, scb_regmap and the host model.
`timescale 1ns/1ps
module tb_serial_controller_byte_regmap;
	logic ref_clk, rst_n, cs, rd, wr, rvalid, rx_push, tx_pop, tx_queue_empty;
	logic clear_send_n, set_ready_n, carrier_n, send_request_n, terminal_ready_n;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, rx_push_data, rx_events, tx_events, tx_head_data;
	logic [15:0] divisor;
	int n_errors = 0;
	int comparisons = 0;
	logic [4:0] rst_ofs [15] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0c, 5'h0d,
		5'h10, 5'h14, 5'h18, 5'h1c, 5'h1d, 5'h1f, 5'h06};
	logic [7:0] rst_val [15] = '{8'h00, 8'h01, 8'h0f, 8'h00, 8'h80, 8'h01, 8'h0f, 8'h00,
		8'h00, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h04, 8'hff};
	logic [4:0] msk_ofs [9] = '{5'h05, 5'h0d, 5'h15, 5'h11, 5'h18, 5'h19, 5'h1a, 5'h1e, 5'h1f};
	logic [7:0] msk_val [9] = '{8'hde, 8'hc6, 8'he0, 8'hc6, 8'h03, 8'h7f, 8'hff, 8'h1f, 8'hcf};
	scb_host_model host (.ref_clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .cs(cs), .rd(rd),
		.wr(wr), .addr(addr), .wdata(wdata));
	scb_regmap uut (.ref_clk(ref_clk), .rst_n(rst_n), .cs(cs), .rd(rd), .wr(wr), .addr(addr),
		.wdata(wdata), .rdata(rdata), .rvalid(rvalid), .rx_push(rx_push),
		.rx_push_data(rx_push_data), .rx_events(rx_events), .tx_pop(tx_pop),
		.tx_events(tx_events), .tx_head_data(tx_head_data), .tx_queue_empty(tx_queue_empty),
		.clear_send_n(clear_send_n), .set_ready_n(set_ready_n), .carrier_n(carrier_n),
		.send_request_n(send_request_n), .terminal_ready_n(terminal_ready_n),
		.receiver_control(), .transmitter_control(), .receiver_irq_enable(),
		.transmitter_irq_enable(), .modem_irq_enable(), .receiver_vector_number(),
		.transmitter_vector_number(), .modem_vector_number(), .modem_line_control(),
		.protocol_select_low(), .protocol_select_high(), .station_address_pad(),
		.station_address_sync(), .divisor(divisor), .clocking_control(), .check_control());
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic end_sim;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.read_reg(a, d, ok);
		if (ok !== 1'h1) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h no answer", $time, 8'h00, exp);
			end_sim();
		end else begin
			check({8'h00, d}, {8'h00, exp});
		end
	endtask
	// engine-side pulses, one cycle wide
	task automatic ev(input logic [7:0] rxe, input logic [7:0] txe, input logic pop);
		@(posedge ref_clk);
		rx_events <= rxe;
		tx_events <= txe;
		tx_pop <= pop;
		@(posedge ref_clk);
		rx_events <= 8'h00;
		tx_events <= 8'h00;
		tx_pop <= 1'h0;
	endtask
	task automatic push_rx(input logic [7:0] d);
		@(posedge ref_clk);
		rx_push <= 1'h1;
		rx_push_data <= d;
		@(posedge ref_clk);
		rx_push <= 1'h0;
	endtask
	initial begin
		rst_n = 1'h0;
		rx_push = 1'h0;
		rx_push_data = 8'h00;
		rx_events = 8'h00;
		tx_events = 8'h00;
		tx_pop = 1'h0;
		clear_send_n = 1'h1;
		set_ready_n = 1'h1;
		carrier_n = 1'h1;
		tick(12);
		rst_n <= 1'h1;
		for (int i = 0; i < 15; i++) rd_chk(rst_ofs[i], rst_val[i]);
		for (int i = 0; i < 9; i++) begin
			host.write_reg(msk_ofs[i], 8'hff);
			rd_chk(msk_ofs[i], msk_val[i]);
		end
		check({15'h0000, send_request_n}, 16'h0000);
		check({15'h0000, terminal_ready_n}, 16'h0000);
		host.write_reg(5'h1c, 8'h34);
		host.write_reg(5'h1d, 8'h12);
		tick(3);
		check(divisor, 16'h1234);
		clear_send_n <= 1'h0;
		set_ready_n <= 1'h0;
		tick(6);
		rd_chk(5'h10, 8'hd8);
		host.write_reg(5'h10, 8'hff);
		rd_chk(5'h10, 8'h18);
		host.write_reg(5'h01, 8'h00);
		push_rx(8'ha1);
		push_rx(8'hb2);
		push_rx(8'hc3);
		rd_chk(5'h00, 8'h80);
		host.write_reg(5'h02, 8'h5a);
		rd_chk(5'h02, 8'ha1);
		rd_chk(5'h02, 8'hb2);
		rd_chk(5'h02, 8'hc3);
		rd_chk(5'h00, 8'h00);
		rd_chk(5'h02, 8'h00);
		ev(8'h04, 8'h00, 1'h0);
		rd_chk(5'h00, 8'h04);
		host.write_reg(5'h00, 8'h04);
		rd_chk(5'h00, 8'h00);
		ev(8'h02, 8'h00, 1'h0);
		host.write_reg(5'h01, 8'h01);
		rd_chk(5'h00, 8'h00);
		for (int i = 0; i < 8; i++) host.write_reg(5'h0a, 8'h10 + 8'(i));
		tick(1);
		check({15'h0000, tx_queue_empty}, 16'h0000);
		check({8'h00, tx_head_data}, 16'h0010);
		rd_chk(5'h08, 8'h00);
		ev(8'h00, 8'h00, 1'h1);
		tick(1);
		check({8'h00, tx_head_data}, 16'h0011);
		rd_chk(5'h08, 8'h80);
		ev(8'h00, 8'h46, 1'h0);
		rd_chk(5'h08, 8'hc6);
		host.write_reg(5'h08, 8'hff);
		rd_chk(5'h08, 8'h80);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		tick(2);
		rst_n <= 1'h1;
		tick(1);
		check({15'h0000, tx_queue_empty}, 16'h0001);
		check({8'h00, tx_head_data}, 16'h0010);
		rd_chk(5'h08, 8'h80);
		rd_chk(5'h00, 8'h00);
		rd_chk(5'h1c, 8'h01);
		end_sim();
	end
endmodule
